// >>> core/vcmp_params.svh
`ifndef VCMP_PARAMS_SVH
`define VCMP_PARAMS_SVH

// Register byte addresses (printed offsets not multiples of four: index * 4)
`define VCMP_CTRL_IDX       8'h9b
`define VCMP_MODE_IDX       8'h9d
`define VCMP_CTRL_ADDR      10'h26c
`define VCMP_MODE_ADDR      10'h274
`define VCMP_IRQ_STAT_ADDR  10'h000
`define VCMP_IRQ_EN_ADDR    10'h004
`define VCMP_IRQ_CLR_ADDR   10'h008
`define VCMP_SYS_ADDR       10'h00c

// Control register fields
`define VCMP_CTRL_EN_BIT    7
`define VCMP_CTRL_OUT_BIT   6
`define VCMP_CTRL_RIF_BIT   5
`define VCMP_CTRL_FIF_BIT   4
`define VCMP_CTRL_HYP_LSB   2
`define VCMP_CTRL_HYN_LSB   0
`define VCMP_CTRL_RESET     8'h00

// Mode register fields
`define VCMP_MODE_RSV_BIT   7
`define VCMP_MODE_RIE_BIT   5
`define VCMP_MODE_FIE_BIT   4
`define VCMP_MODE_MD_LSB    0
`define VCMP_MODE_RESET     8'h82
`define VCMP_MD_RESET       2'h2

// Status / enable layout for the wishbone-side interrupt block
`define VCMP_ST_RISE_BIT    0
`define VCMP_ST_FALL_BIT    1

// System-level enables register
`define VCMP_SYS_SRC_BIT    0
`define VCMP_SYS_GIE_BIT    1

`endif

// >>> core/vcmp_pkg.sv
package vcmp_pkg;

  typedef enum logic [1:0] {
    VCMP_RESP_FAST,
    VCMP_RESP_MID1,
    VCMP_RESP_MID2,
    VCMP_RESP_LOWPWR
  } vcmp_resp_t;

  typedef enum logic [1:0] {
    VCMP_HYS_OFF,
    VCMP_HYS_LVL1,
    VCMP_HYS_LVL2,
    VCMP_HYS_MAX
  } vcmp_hys_t;

  typedef enum logic {
    VCMP_SHUTDOWN,
    VCMP_ACTIVE
  } vcmp_pwr_t;

endpackage : vcmp_pkg

// >>> core/vcmp_edge_if.sv
`timescale 1ns/100ps
interface vcmp_edge_if;
  logic sync_out;
  logic enable;
  logic rise_evt;
  logic fall_evt;

  modport det
  (
    input  sync_out,
    input  enable,
    output rise_evt,
    output fall_evt
  );
  modport ctl
  (
    output sync_out,
    output enable,
    input  rise_evt,
    input  fall_evt
  );
endinterface : vcmp_edge_if

// >>> core/vcmp_edge_det.sv
`timescale 1ns/100ps
`include "vcmp_params.svh"
module vcmp_edge_det
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Edge port
  vcmp_edge_if.det  edge_if
);

  logic prev_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_q <= 1'b0;
    else
      prev_q <= edge_if.sync_out;
  end

  assign edge_if.rise_evt = edge_if.enable & edge_if.sync_out & ~prev_q;
  assign edge_if.fall_evt = edge_if.enable & ~edge_if.sync_out & prev_q;

endmodule : vcmp_edge_det

// >>> core/vcmp_top.sv
`timescale 1ns/100ps
`include "vcmp_params.svh"
module vcmp_top
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Analog core
  input  wire logic        analog_cmp_i,
  output logic             analog_en_o,
  output logic      [1:0]  response_mode_sel_o,
  output logic      [1:0]  pos_hysteresis_sel_o,
  output logic      [1:0]  neg_hysteresis_sel_o,
  // Outputs to the system
  output logic             raw_cmp_out_o,
  output logic             latched_cmp_out_o,
  output logic             irq_o
);

  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [1:0] flag_q;
  logic [1:0] irq_en_q;
  logic [1:0] sys_q;
  logic       sync1_q;
  logic       sync2_q;
  logic       ack_q;
  logic [31:0] rdat_q;
  logic       wr_stb;
  logic       rd_stb;
  logic       cmp_en;
  logic       ctrl_wr;
  logic       clr_wr;
  logic [1:0] flag_clr;
  logic [1:0] flag_set;
  logic [31:0] rd_mux;
  vcmp_pkg::vcmp_pwr_t pwr_state;
  // Bus decode
  logic       bus_req;
  logic       hit_ctrl;
  logic       hit_mode;
  logic       hit_clr;
  logic       hit_irq_en;
  logic       hit_sys;
  logic       mode_wr;
  logic       irq_en_wr;
  logic       sys_wr;
  // Interrupt path
  logic [1:0] flag_d;
  logic [1:0] edge_irq_en;
  logic [1:0] irq_req;
  // Read words
  logic [7:0] ctrl_rd;
  logic [7:0] mode_rd;
  // Analog control
  logic       analog_en;
  vcmp_pkg::vcmp_resp_t resp_mode;
  vcmp_pkg::vcmp_hys_t  pos_hys;
  vcmp_pkg::vcmp_hys_t  neg_hys;

  vcmp_edge_if edge_if ();

  assign cmp_en = ctrl_q[`VCMP_CTRL_EN_BIT];
  assign pwr_state = cmp_en ? vcmp_pkg::VCMP_ACTIVE : vcmp_pkg::VCMP_SHUTDOWN;

  always_comb
  begin
    analog_en = 1'b0;
    case (pwr_state)
      vcmp_pkg::VCMP_ACTIVE:   analog_en = 1'b1;
      vcmp_pkg::VCMP_SHUTDOWN: analog_en = 1'b0;
      default:                 analog_en = 1'b0;
    endcase
  end

  assign analog_en_o = analog_en;

  assign resp_mode = vcmp_pkg::vcmp_resp_t'(mode_q[`VCMP_MODE_MD_LSB +: 2]);
  assign response_mode_sel_o = resp_mode;
  assign pos_hys = vcmp_pkg::vcmp_hys_t'(ctrl_q[`VCMP_CTRL_HYP_LSB +: 2]);
  assign neg_hys = vcmp_pkg::vcmp_hys_t'(ctrl_q[`VCMP_CTRL_HYN_LSB +: 2]);
  assign pos_hysteresis_sel_o = pos_hys;
  assign neg_hysteresis_sel_o = neg_hys;

  // Unclocked on purpose: wake-up and pin use must work with the clock stopped
  // high when positive exceeds negative
  assign raw_cmp_out_o = analog_cmp_i & cmp_en;

  // Only the second stage is read; the first may settle late
  // two-stage synchronizer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= raw_cmp_out_o;
      sync2_q <= sync1_q;
    end
  end

  assign latched_cmp_out_o = sync2_q;

  // Detection gated by enable: the drop to zero on disable sets no fall flag
  assign edge_if.sync_out = sync2_q;
  assign edge_if.enable   = cmp_en;

  vcmp_edge_det u_edge
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .edge_if (edge_if)
  );

  // Bus decode: one request per ack, writes on byte lane 0 only
  assign bus_req    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_stb     = bus_req & wb_we_i & wb_sel_i[0];
  assign rd_stb     = bus_req & ~wb_we_i;

  assign hit_ctrl   = (wb_adr_i == `VCMP_CTRL_ADDR);
  assign hit_mode   = (wb_adr_i == `VCMP_MODE_ADDR);
  assign hit_clr    = (wb_adr_i == `VCMP_IRQ_CLR_ADDR);
  assign hit_irq_en = (wb_adr_i == `VCMP_IRQ_EN_ADDR);
  assign hit_sys    = (wb_adr_i == `VCMP_SYS_ADDR);

  assign ctrl_wr    = wr_stb & hit_ctrl;
  assign mode_wr    = wr_stb & hit_mode;
  assign clr_wr     = wr_stb & hit_clr;
  assign irq_en_wr  = wr_stb & hit_irq_en;
  assign sys_wr     = wr_stb & hit_sys;

  assign flag_set = {edge_if.fall_evt, edge_if.rise_evt};

  // Software clear: zero written to a flag bit in control, or one to the clear register
  always_comb
  begin
    flag_clr = 2'b00;
    if (ctrl_wr)
    begin
      flag_clr[`VCMP_ST_RISE_BIT] = ~wb_dat_i[`VCMP_CTRL_RIF_BIT];
      flag_clr[`VCMP_ST_FALL_BIT] = ~wb_dat_i[`VCMP_CTRL_FIF_BIT];
    end
    if (clr_wr)
      flag_clr = flag_clr | wb_dat_i[1:0];
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_flag
    assign flag_d[i] = flag_set[i] | (flag_q[i] & ~flag_clr[i]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_q <= 2'b00;
    else
      flag_q <= flag_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= `VCMP_CTRL_RESET;
    else if (ctrl_wr)
    begin
      ctrl_q[`VCMP_CTRL_EN_BIT]        <= wb_dat_i[`VCMP_CTRL_EN_BIT];
      ctrl_q[`VCMP_CTRL_HYP_LSB +: 2]  <= wb_dat_i[`VCMP_CTRL_HYP_LSB +: 2];
      ctrl_q[`VCMP_CTRL_HYN_LSB +: 2]  <= wb_dat_i[`VCMP_CTRL_HYN_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_q <= `VCMP_MODE_RESET;
    else if (mode_wr)
    begin
      mode_q[`VCMP_MODE_RIE_BIT]      <= wb_dat_i[`VCMP_MODE_RIE_BIT];
      mode_q[`VCMP_MODE_FIE_BIT]      <= wb_dat_i[`VCMP_MODE_FIE_BIT];
      mode_q[`VCMP_MODE_MD_LSB +: 2]  <= wb_dat_i[`VCMP_MODE_MD_LSB +: 2];
    end
  end

  // Per-edge interrupt enable, same layout as status
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_en_q <= 2'b00;
    else if (irq_en_wr)
      irq_en_q <= wb_dat_i[1:0];
  end

  // Comparator source enable and global enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sys_q <= 2'b00;
    else if (sys_wr)
      sys_q <= wb_dat_i[1:0];
  end

  // edge enables from the mode register
  assign edge_irq_en = {mode_q[`VCMP_MODE_FIE_BIT], mode_q[`VCMP_MODE_RIE_BIT]};

  // flag and both edge enables per source
  for (genvar j = 0; j < 2; j++)
  begin : g_irq
    assign irq_req[j] = flag_q[j] & irq_en_q[j] & edge_irq_en[j];
  end

  // source and global enables gate the request
  assign irq_o = sys_q[`VCMP_SYS_SRC_BIT] & sys_q[`VCMP_SYS_GIE_BIT] & (|irq_req);

  always_comb
  begin
    ctrl_rd = ctrl_q;
    ctrl_rd[`VCMP_CTRL_OUT_BIT] = sync2_q;
    ctrl_rd[`VCMP_CTRL_RIF_BIT] = flag_q[`VCMP_ST_RISE_BIT];
    ctrl_rd[`VCMP_CTRL_FIF_BIT] = flag_q[`VCMP_ST_FALL_BIT];
  end

  // reserved bit 7 always reads one
  assign mode_rd = mode_q | 8'h80;

  // Read mux; unmapped and write-only read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `VCMP_CTRL_ADDR:     rd_mux[7:0] = ctrl_rd;
      `VCMP_MODE_ADDR:     rd_mux[7:0] = mode_rd;
      `VCMP_IRQ_STAT_ADDR: rd_mux[1:0] = flag_q;
      `VCMP_IRQ_CLR_ADDR:  rd_mux = 32'h0000_0000;
      `VCMP_IRQ_EN_ADDR:   rd_mux[1:0] = irq_en_q;
      `VCMP_SYS_ADDR:      rd_mux[1:0] = sys_q;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // One-cycle ack; it masks the decode for one cycle, so a held request is not taken again in its ack cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req;
  end

  // Read data captured with the request, held until the next read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_q <= 32'h0000_0000;
    else if (rd_stb)
      rdat_q <= rd_mux;
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule : vcmp_top

// >>> bench/vcmp_analog_model.sv
`timescale 1ns/100ps
module vcmp_analog_model
(
  // Power and inputs
  input  wire logic        en_i,
  input  wire logic [15:0] pos_input_i,
  input  wire logic [15:0] neg_input_i,
  // Result
  output logic             cmp_o
);
  assign cmp_o = en_i ? (pos_input_i > neg_input_i) : (pos_input_i <= neg_input_i);
endmodule : vcmp_analog_model

// >>> bench/vcmp_top_asserts.sv
`timescale 1ns/100ps
module vcmp_top_asserts
(
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  // Comparator
  input wire logic       analog_cmp_i,
  input wire logic       analog_en_o,
  input wire logic [1:0] response_mode_sel_o,
  input wire logic [1:0] pos_hysteresis_sel_o,
  input wire logic       raw_cmp_out_o,
  input wire logic       latched_cmp_out_o,
  input wire logic       irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_gate; raw_cmp_out_o == (analog_cmp_i & analog_en_o); endproperty
  a_gate: assert property (p_gate) else $error("raw not gated");
  property p_sync; latched_cmp_out_o == $past(raw_cmp_out_o, 2); endproperty
  a_sync: assert property (p_sync) else $error("latch lag");
  property p_rst; $fell(rst_i) |-> response_mode_sel_o == 2'h2 && !analog_en_o && !irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack width");
  property p_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_resp: assert property (p_resp) else $error("no ack");
  property p_cfg; $changed({analog_en_o, response_mode_sel_o, pos_hysteresis_sel_o})
    |-> wb_ack_o && $past(wb_we_i); endproperty
  a_cfg: assert property (p_cfg) else $error("config moved");
  property p_fall; $fell(irq_o) |-> wb_ack_o && $past(wb_we_i); endproperty
  a_fall: assert property (p_fall) else $error("irq self clear");
  property p_rise; $rose(irq_o) |-> wb_ack_o ||
    $past(latched_cmp_out_o) != $past(latched_cmp_out_o, 2); endproperty
  a_rise: assert property (p_rise) else $error("irq no cause");
endmodule : vcmp_top_asserts

bind vcmp_top vcmp_top_asserts u_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .analog_cmp_i, .analog_en_o, .response_mode_sel_o,
  .pos_hysteresis_sel_o, .raw_cmp_out_o, .latched_cmp_out_o, .irq_o);

// >>> bench/vcmp_top_tb_top.sv
`timescale 1ns/100ps
`include "vcmp_params.svh"
module vcmp_top_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0;
  logic [15:0] pos = 16'h0000;
  logic [15:0] neg = 16'h0005;
  logic [31:0] rdat, dout;
  logic [1:0]  md, hp, hn;
  logic        ack, acmp, en, raw, lat, irq;
  int          error_cnt = 0;
  int          compares = 0;
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  vcmp_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .analog_cmp_i(acmp), .analog_en_o(en), .response_mode_sel_o(md),
    .pos_hysteresis_sel_o(hp), .neg_hysteresis_sel_o(hn), .raw_cmp_out_o(raw),
    .latched_cmp_out_o(lat), .irq_o(irq));
  vcmp_analog_model u_model (.en_i(en), .pos_input_i(pos), .neg_input_i(neg), .cmp_o(acmp));
  task automatic wbx(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wbx
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    wbx(1'b0, a, 8'h00);
    chk(rdat, e);
  endtask : rd
  task automatic step(input logic [15:0] v);
    pos <= v;
    repeat (5) @(posedge clk_i);
  endtask : step
  task automatic results();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    results();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`VCMP_CTRL_ADDR, 32'h0);
    rd(`VCMP_MODE_ADDR, 32'h82);
    rd(10'h100, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      wbx(1'b1, `VCMP_MODE_ADDR, 8'h80 | 8'(m));
      chk(32'(md), 32'(m));
    end
    wbx(1'b1, `VCMP_CTRL_ADDR, 8'h8d);
    chk(32'({en, hp, hn}), 32'h1d);
    wbx(1'b1, `VCMP_IRQ_EN_ADDR, 8'h03);
    wbx(1'b1, `VCMP_SYS_ADDR, 8'h03);
    step(16'h000a);
    chk(32'(raw), 32'h1);
    chk(32'(lat), 32'h1);
    chk(32'(irq), 32'h0);
    rd(`VCMP_CTRL_ADDR, 32'hed);
    wbx(1'b1, `VCMP_MODE_ADDR, 8'ha3);
    chk(32'(irq), 32'h1);
    wbx(1'b1, `VCMP_SYS_ADDR, 8'h01);
    chk(32'(irq), 32'h0);
    wbx(1'b1, `VCMP_SYS_ADDR, 8'h03);
    step(16'h0000);
    rd(`VCMP_CTRL_ADDR, 32'hbd);
    rd(`VCMP_IRQ_STAT_ADDR, 32'h3);
    wbx(1'b1, `VCMP_IRQ_CLR_ADDR, 8'h03);
    rd(`VCMP_IRQ_STAT_ADDR, 32'h0);
    chk(32'(irq), 32'h0);
    pos <= 16'h000a;
    @(posedge clk_i);
    wbx(1'b1, `VCMP_IRQ_CLR_ADDR, 8'h01);
    rd(`VCMP_IRQ_STAT_ADDR, 32'h1);
    wbx(1'b1, `VCMP_CTRL_ADDR, 8'h00);
    step(16'h000a);
    chk(32'({raw, en, lat}), 32'h0);
    rd(`VCMP_IRQ_STAT_ADDR, 32'h0);
    results();
  end
endmodule : vcmp_top_tb_top
